// File: verilog/actrim_defines.svh
// Offsets, field positions and frame timing for the converter trim bank.
// Assumes inclusion by bare name in the package and the design file.
`ifndef ACTRIM_DEFINES_SVH
`define ACTRIM_DEFINES_SVH

// ==========================================
// Register offsets on the configuration port
`define ACTRIM_ADDR_TB_S1 15'h0315
`define ACTRIM_ADDR_TA_S2 15'h031A
`define ACTRIM_ADDR_TB_S2 15'h031B
`define ACTRIM_ADDR_OA_D1_LO 15'h0344
`define ACTRIM_ADDR_OA_D1_HI 15'h0345
`define ACTRIM_ADDR_OA_D2_LO 15'h0346
`define ACTRIM_ADDR_OA_D2_HI 15'h0347

// ==========================================
// Field positions and reset values
`define ACTRIM_TIMING_MSB 7
`define ACTRIM_OFFSET_MSB 11
`define ACTRIM_RSVD_MSB 15
`define ACTRIM_TIMING_RST 8'h00
`define ACTRIM_OFFSET_RST 16'h0000
// Reserved nibbles of both offsets inside the stored register set
`define ACTRIM_RSVD_MASK 56'h00_0000_F000_F000
// Pin idle levels after reset: sclk low, sen_n high, sdi low
`define ACTRIM_SYNC_RST 3'h2

// ==========================================
// Frame layout: one read flag, 15 address bits, 8 data bits
`define ACTRIM_HDR_BITS 5'h10
`define ACTRIM_FRAME_BITS 5'h18
`define ACTRIM_RW_BIT 15

`endif

// File: verilog/actrim_pkg.sv
// Types shared by the converter trim bank.
// Assumes actrim_defines.svh is on the include path.
`include "actrim_defines.svh"

package actrim_pkg;

  // ==========================================
  // Operating mode seen by the trim selection
  typedef struct packed {
    logic single_mode;   // Single channel when high, dual when low
    logic second_input;  // Second input pair sampled when high
    logic fg_cal_en;     // Foreground calibration enabled
  } actrim_mode_t;

  // ==========================================
  // Factory fuse image, also the stored register set
  typedef struct packed {
    logic [7:0] b_core_timing_trim_single_first_input;
    logic [7:0] a_core_timing_trim_single_second_input;
    logic [7:0] b_core_timing_trim_single_second_input;
    logic [15:0] a_core_offset_trim_dual_first_input;
    logic [15:0] a_core_offset_trim_dual_second_input;
  } actrim_regs_t;

  // ==========================================
  // Trims presented to the converter cores
  typedef struct packed {
    logic a_timing_valid;
    logic [7:0] a_timing;
    logic b_timing_valid;
    logic [7:0] b_timing;
    logic a_offset_valid;
    logic [11:0] a_offset;
  } actrim_applied_t;

endpackage : actrim_pkg

// File: verilog/actrim_core.sv
// Trim register bank: serial configuration slave plus mode-based trim selection.
// Assumes pin inputs are asynchronous to clock; mode and fuse come from clock domain.
`timescale 1ns/10ps
`default_nettype none
`include "actrim_defines.svh"

// Contract
// [RL1] Timing trims are 8-bit read/write low byte
// [RL2] B timing first input: single, FG cal
// [RL3] A timing second input: single, FG cal
// [RL4] B timing second input: single, FG cal
// [RL5] Offset trims 12-bit, upper four reserved RW
// [RL6] A offset first input: dual, FG cal
// [RL7] A offset second input: dual, FG cal
// [RL8] Power-up contents loaded from fuse memory
// [RL9] Trims readable and writable by software
// [RL10] Values retained while other mode active
module actrim_core (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cfg_sclk,
  input wire logic cfg_sen_n,
  input wire logic cfg_sdi,
  output logic cfg_sdo,
  output logic cfg_sdo_oe,
  input wire actrim_pkg::actrim_mode_t mode,
  input wire actrim_pkg::actrim_regs_t fuse_image,
  output actrim_pkg::actrim_applied_t applied
);
  import actrim_pkg::*;

  // ==========================================
  // Pin synchronisers
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic sclk_prev_q;
  logic sclk_s, sen_n_s, sdi_s, sclk_rise, sclk_fall;

  // Two flops per pin, then an edge history on the second stage
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= `ACTRIM_SYNC_RST; // Idle levels, so no false sclk edge follows reset
      sync2_q <= `ACTRIM_SYNC_RST;
      sclk_prev_q <= 1'b0;
    end else begin
      sync1_q <= {cfg_sclk, cfg_sen_n, cfg_sdi};
      sync2_q <= sync1_q;
      sclk_prev_q <= sync2_q[2];
    end
  end

  assign sclk_s = sync2_q[2];
  assign sen_n_s = sync2_q[1];
  assign sdi_s = sync2_q[0];
  assign sclk_rise = sclk_s && !sclk_prev_q && !sen_n_s;
  assign sclk_fall = !sclk_s && sclk_prev_q && !sen_n_s;

  // ==========================================
  // Frame shifter
  logic [4:0] bit_cnt_q;
  logic [23:0] shift_q;
  logic [23:0] shift_d;
  logic [14:0] addr_q;
  logic reading_q;
  logic [7:0] sdo_sh_q;
  logic sdo_q;
  logic wr_en;

  assign shift_d = {shift_q[22:0], sdi_s};
  assign wr_en = sclk_rise && (bit_cnt_q == `ACTRIM_FRAME_BITS - 5'h01) && !reading_q;

  // Read data for one byte address
  function automatic logic [7:0] rd_byte(input logic [14:0] a, input actrim_regs_t r);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      `ACTRIM_ADDR_TB_S1: v = r.b_core_timing_trim_single_first_input;
      `ACTRIM_ADDR_TA_S2: v = r.a_core_timing_trim_single_second_input;
      `ACTRIM_ADDR_TB_S2: v = r.b_core_timing_trim_single_second_input;
      `ACTRIM_ADDR_OA_D1_LO: v = r.a_core_offset_trim_dual_first_input[7:0];
      `ACTRIM_ADDR_OA_D1_HI: v = r.a_core_offset_trim_dual_first_input[15:8];
      `ACTRIM_ADDR_OA_D2_LO: v = r.a_core_offset_trim_dual_second_input[7:0];
      `ACTRIM_ADDR_OA_D2_HI: v = r.a_core_offset_trim_dual_second_input[15:8];
      default: v = 8'h00;
    endcase
    return v;
  endfunction : rd_byte

  actrim_regs_t regs_q;

  // Bit counting, header capture, readback shift
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_q <= 5'h00;
      shift_q <= 24'h00_0000;
      addr_q <= 15'h0000;
      reading_q <= 1'b0;
      sdo_sh_q <= 8'h00;
      sdo_q <= 1'b0;
    end else if (sen_n_s) begin
      bit_cnt_q <= 5'h00;
      reading_q <= 1'b0;
      sdo_q <= 1'b0;
    end else begin
      if (sclk_rise && bit_cnt_q != `ACTRIM_FRAME_BITS) begin
        shift_q <= shift_d;
        bit_cnt_q <= bit_cnt_q + 5'h01;
        if (bit_cnt_q == `ACTRIM_HDR_BITS - 5'h01) begin
          addr_q <= shift_d[14:0];
          reading_q <= shift_d[`ACTRIM_RW_BIT];
          sdo_sh_q <= rd_byte(shift_d[14:0], regs_q); // see [RL9]
        end
      end
      if (sclk_fall && reading_q && bit_cnt_q >= `ACTRIM_HDR_BITS) begin
        sdo_q <= sdo_sh_q[7];
        sdo_sh_q <= {sdo_sh_q[6:0], 1'b0};
      end
    end
  end

  assign cfg_sdo = sdo_q;
  assign cfg_sdo_oe = reading_q && !sen_n_s;

  // ==========================================
  // Register storage with fuse load
  logic load_pend_q;

  // Fuse image taken once, at the first edge after reset release
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      load_pend_q <= 1'b1;
    end else begin
      load_pend_q <= 1'b0;
    end
  end

  // Byte writes; offsets keep all 16 bits including reserved nibble
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      regs_q.b_core_timing_trim_single_first_input <= `ACTRIM_TIMING_RST;
      regs_q.a_core_timing_trim_single_second_input <= `ACTRIM_TIMING_RST;
      regs_q.b_core_timing_trim_single_second_input <= `ACTRIM_TIMING_RST;
      regs_q.a_core_offset_trim_dual_first_input <= `ACTRIM_OFFSET_RST;
      regs_q.a_core_offset_trim_dual_second_input <= `ACTRIM_OFFSET_RST;
    end else if (load_pend_q) begin
      regs_q <= fuse_image & ~`ACTRIM_RSVD_MASK; // see [RL8] [RL5]
    end else if (wr_en) begin // see [RL10]
      unique case (addr_q)
        `ACTRIM_ADDR_TB_S1: regs_q.b_core_timing_trim_single_first_input <= shift_d[7:0]; // see [RL1]
        `ACTRIM_ADDR_TA_S2: regs_q.a_core_timing_trim_single_second_input <= shift_d[7:0];
        `ACTRIM_ADDR_TB_S2: regs_q.b_core_timing_trim_single_second_input <= shift_d[7:0];
        `ACTRIM_ADDR_OA_D1_LO: regs_q.a_core_offset_trim_dual_first_input[7:0] <= shift_d[7:0];
        `ACTRIM_ADDR_OA_D1_HI: regs_q.a_core_offset_trim_dual_first_input[15:8] <= shift_d[7:0]; // see [RL5]
        `ACTRIM_ADDR_OA_D2_LO: regs_q.a_core_offset_trim_dual_second_input[7:0] <= shift_d[7:0];
        `ACTRIM_ADDR_OA_D2_HI: regs_q.a_core_offset_trim_dual_second_input[15:8] <= shift_d[7:0];
        default: ;
      endcase
    end
  end

  // ==========================================
  // Trim selection by mode
  logic sel_tb_s1, sel_ta_s2, sel_tb_s2, sel_oa_d1, sel_oa_d2;
  actrim_applied_t applied_q;

  assign sel_tb_s1 = mode.single_mode && !mode.second_input && mode.fg_cal_en;
  assign sel_ta_s2 = mode.single_mode && mode.second_input && mode.fg_cal_en;
  assign sel_tb_s2 = sel_ta_s2;
  assign sel_oa_d1 = !mode.single_mode && !mode.second_input && mode.fg_cal_en;
  assign sel_oa_d2 = !mode.single_mode && mode.second_input && mode.fg_cal_en;

  // Registered trims; zero with valid low when no stored trim qualifies
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      applied_q <= '0;
    end else begin
      applied_q.a_timing_valid <= sel_ta_s2; // see [RL3]
      applied_q.a_timing <= sel_ta_s2 ? regs_q.a_core_timing_trim_single_second_input : 8'h00;
      applied_q.b_timing_valid <= sel_tb_s1 || sel_tb_s2;
      applied_q.b_timing <= sel_tb_s1 ? regs_q.b_core_timing_trim_single_first_input : // see [RL2]
        sel_tb_s2 ? regs_q.b_core_timing_trim_single_second_input : 8'h00; // see [RL4]
      applied_q.a_offset_valid <= sel_oa_d1 || sel_oa_d2;
      applied_q.a_offset <= sel_oa_d1 ? regs_q.a_core_offset_trim_dual_first_input[11:0] : // see [RL6]
        sel_oa_d2 ? regs_q.a_core_offset_trim_dual_second_input[11:0] : 12'h000; // see [RL7]
    end
  end

  assign applied = applied_q;

  // ==========================================
  // Checks
  property p_rl2;
    @(posedge clock) disable iff (!rst_n)
      sel_tb_s1 |=> applied.b_timing_valid
        && applied.b_timing == $past(regs_q.b_core_timing_trim_single_first_input);
  endproperty
  a_rl2: assert property (p_rl2) else $error("B first input timing trim not applied"); // see [RL2]

  property p_rl3;
    @(posedge clock) disable iff (!rst_n)
      sel_ta_s2 |=> applied.a_timing == $past(regs_q.a_core_timing_trim_single_second_input);
  endproperty
  a_rl3: assert property (p_rl3) else $error("A second input timing trim not applied"); // see [RL3]

  property p_rl4;
    @(posedge clock) disable iff (!rst_n)
      sel_tb_s2 |=> applied.b_timing == $past(regs_q.b_core_timing_trim_single_second_input);
  endproperty
  a_rl4: assert property (p_rl4) else $error("B second input timing trim not applied"); // see [RL4]

  property p_rl6;
    @(posedge clock) disable iff (!rst_n)
      sel_oa_d1 |=> applied.a_offset_valid
        && applied.a_offset == $past(regs_q.a_core_offset_trim_dual_first_input[11:0]);
  endproperty
  a_rl6: assert property (p_rl6) else $error("A first input offset not applied"); // see [RL6]

  property p_rl7;
    @(posedge clock) disable iff (!rst_n)
      sel_oa_d2 |=> applied.a_offset == $past(regs_q.a_core_offset_trim_dual_second_input[11:0]);
  endproperty
  a_rl7: assert property (p_rl7) else $error("A second input offset not applied"); // see [RL7]

  property p_rl8;
    @(posedge clock) disable iff (!rst_n)
      load_pend_q |=> regs_q == ($past(fuse_image) & ~`ACTRIM_RSVD_MASK) && !load_pend_q;
  endproperty
  a_rl8: assert property (p_rl8) else $error("Fuse image not loaded after reset"); // see [RL8]

  property p_rl1;
    @(posedge clock) disable iff (!rst_n)
      wr_en && addr_q == `ACTRIM_ADDR_TA_S2 && !load_pend_q
        |=> regs_q.a_core_timing_trim_single_second_input == $past(shift_d[7:0]);
  endproperty
  a_rl1: assert property (p_rl1) else $error("Timing trim write lost"); // see [RL1]

  property p_rl5;
    @(posedge clock) disable iff (!rst_n)
      wr_en && addr_q == `ACTRIM_ADDR_OA_D2_HI && !load_pend_q
        |=> regs_q.a_core_offset_trim_dual_second_input[15:8] == $past(shift_d[7:0]);
  endproperty
  a_rl5: assert property (p_rl5) else $error("Offset high byte write lost"); // see [RL5]

  property p_rl10;
    @(posedge clock) disable iff (!rst_n)
      !wr_en && !load_pend_q |=> $stable(regs_q);
  endproperty
  a_rl10: assert property (p_rl10) else $error("Trim changed without a write"); // see [RL10]

  property p_rl9;
    @(posedge clock) disable iff (!rst_n)
      sclk_rise && bit_cnt_q == `ACTRIM_HDR_BITS - 5'h01 && shift_d[`ACTRIM_RW_BIT]
        |=> sdo_sh_q == rd_byte($past(shift_d[14:0]), $past(regs_q)) ##1 cfg_sdo_oe;
  endproperty
  a_rl9: assert property (p_rl9) else $error("Readback byte wrong"); // see [RL9]

endmodule : actrim_core
`default_nettype wire

// File: verif/adc_core_trim_registers_tb.sv
// Self-checking bench for the converter trim bank: serial config frames and applied trims.
// Assumes actrim_pkg and actrim_defines.svh compiled first; drives pins at falling edge.
`timescale 1ns/10ps
`default_nettype none
`include "actrim_defines.svh"

module adc_core_trim_registers_tb;
  import actrim_pkg::*;

  // ==========================================
  // Stimulus and observed signals
  logic clock;
  logic rst_n;
  logic cfg_sclk;
  logic cfg_sen_n;
  logic cfg_sdi;
  logic cfg_sdo;
  logic cfg_sdo_oe;
  actrim_mode_t mode;
  actrim_regs_t fuse_image;
  actrim_regs_t shadow;
  actrim_applied_t applied;
  logic [31:0] seed;
  int fail_count;
  int num_checks;
  int cyc;

  actrim_core actrim_core_i (
    .clock(clock), .rst_n(rst_n), .cfg_sclk(cfg_sclk), .cfg_sen_n(cfg_sen_n),
    .cfg_sdi(cfg_sdi), .cfg_sdo(cfg_sdo), .cfg_sdo_oe(cfg_sdo_oe), .mode(mode),
    .fuse_image(fuse_image), .applied(applied)
  );

  // ==========================================
  // Clock and hang guard
  always #50 clock = ~clock;

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      wrap_up();
    end
  end

  // ==========================================
  // Helpers: random source, byte views, expectations
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  function automatic logic [14:0] addr_of(input int j);
    case (j)
      0: return `ACTRIM_ADDR_TB_S1;
      1: return `ACTRIM_ADDR_TA_S2;
      2: return `ACTRIM_ADDR_TB_S2;
      3: return `ACTRIM_ADDR_OA_D1_LO;
      4: return `ACTRIM_ADDR_OA_D1_HI;
      5: return `ACTRIM_ADDR_OA_D2_LO;
      default: return `ACTRIM_ADDR_OA_D2_HI;
    endcase
  endfunction : addr_of

  // Byte j of the register set sits at bits 8*j+7:8*j
  function automatic logic [55:0] to_bytes(input actrim_regs_t r);
    return {r.a_core_offset_trim_dual_second_input, r.a_core_offset_trim_dual_first_input,
            r.b_core_timing_trim_single_second_input, r.a_core_timing_trim_single_second_input,
            r.b_core_timing_trim_single_first_input};
  endfunction : to_bytes

  function automatic actrim_regs_t from_bytes(input logic [55:0] b);
    return {b[7:0], b[15:8], b[23:16], b[39:24], b[55:40]};
  endfunction : from_bytes

  function automatic actrim_applied_t exp_applied(input actrim_mode_t m, input actrim_regs_t r);
    actrim_applied_t e;
    e = '0;
    if (m.fg_cal_en && m.single_mode && !m.second_input) begin
      e.b_timing_valid = 1'b1;
      e.b_timing = r.b_core_timing_trim_single_first_input;
    end else if (m.fg_cal_en && m.single_mode) begin
      e.a_timing_valid = 1'b1;
      e.a_timing = r.a_core_timing_trim_single_second_input;
      e.b_timing_valid = 1'b1;
      e.b_timing = r.b_core_timing_trim_single_second_input;
    end else if (m.fg_cal_en) begin
      e.a_offset_valid = 1'b1;
      e.a_offset = m.second_input ? r.a_core_offset_trim_dual_second_input[11:0]
                                  : r.a_core_offset_trim_dual_first_input[11:0];
    end
    return e;
  endfunction : exp_applied

  // ==========================================
  // Tasks: timing, compare, serial frame, full sweep
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask : tick

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // One 24-bit frame, slow sclk of 4 clocks per phase
  task automatic frame(input logic rd, input logic [14:0] addr, input logic [7:0] wd,
                       output logic [7:0] rdat);
    logic [23:0] word;
    word = {rd, addr, wd};
    rdat = 8'h00;
    cfg_sen_n = 1'b0;
    tick(4);
    for (int i = 23; i >= 0; i--) begin
      cfg_sdi = word[i];
      tick(4);
      if (rd && i < 8) begin
        check(cfg_sdo_oe, 1'b1);
        rdat[i] = cfg_sdo;
      end
      cfg_sclk = 1'b1;
      tick(4);
      cfg_sclk = 1'b0;
    end
    tick(4);
    cfg_sen_n = 1'b1;
    cfg_sdi = ~cfg_sdi;
    tick(8);
    check(cfg_sdo_oe, 1'b0);
  endtask : frame

  // Read back every register, then sweep all eight modes
  task automatic check_all();
    logic [7:0] r;
    logic [55:0] b;
    b = to_bytes(shadow);
    for (int j = 0; j < 7; j++) begin
      frame(1'b1, addr_of(j), 8'h00, r);
      check(r, b[8*j +: 8]);
    end
    for (int m = 0; m < 8; m++) begin
      mode = actrim_mode_t'(m[2:0]);
      tick(2);
      check(applied, exp_applied(mode, shadow));
    end
  endtask : check_all

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up

  // ==========================================
  // Main sequence
  initial begin
    logic [7:0] d;
    logic [55:0] b;
    clock = 1'b0;
    rst_n = 1'b0;
    cfg_sclk = 1'b0;
    cfg_sen_n = 1'b1;
    cfg_sdi = 1'b0;
    mode = '0;
    fuse_image = '0;
    seed = 32'h0001_5372;
    fail_count = 0;
    num_checks = 0;
    cyc = 0;
    // Two resets, each with a fresh fuse image
    for (int p = 0; p < 2; p++) begin
      seed = lfsr_next(seed);
      fuse_image[55:32] = seed[23:0];
      seed = lfsr_next(seed);
      fuse_image[31:0] = seed;
      // Reserved offset nibbles come up zero whatever the fuses hold
      shadow = fuse_image & ~`ACTRIM_RSVD_MASK;
      rst_n = 1'b0;
      tick(3);
      check(applied, 31'h0000_0000);
      rst_n = 1'b1;
      tick(3);
      check_all();
    end
    fuse_image = ~fuse_image;
    // Writes: all ones, all zeros, then random bytes
    for (int k = 0; k < 3; k++) begin
      b = to_bytes(shadow);
      for (int j = 0; j < 7; j++) begin
        seed = lfsr_next(seed);
        d = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : seed[7:0];
        frame(1'b0, addr_of(j), d, d);
        b[8*j +: 8] = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : seed[7:0];
      end
      shadow = from_bytes(b);
      check_all();
    end
    // Unmapped place between trims reads zero and changes nothing
    frame(1'b0, 15'h0316, 8'hA5, d);
    frame(1'b1, 15'h0316, 8'h00, d);
    check(d, 8'h00);
    check_all();
    wrap_up();
  end

endmodule : adc_core_trim_registers_tb
`default_nettype wire
